// ===== shared/jk_pkg.sv
// Shared types and constants for the dual J/not-K flip-flop block
package jk_pkg;
    // Number of independent channels
    localparam int CHANNELS = 2;
    // Reset value of each channel's true output
    localparam logic STATE_RESET = 1'b0;
    // Per-channel pin inputs, all from the board
    typedef struct packed {
        logic clk_pin;
        logic j;
        logic k_n;
        logic async_set_n;
        logic async_reset_n;
    } chan_in_type;
    // Per-channel outputs
    typedef struct packed {
        logic q;
        logic q_n;
    } chan_out_type;
endpackage

// ===== logic/dual_jk_flip_flop.sv
// Dual positive-edge J/not-K flip-flop block, sampled on the system clock
// Function
// - Two independent channels, each with own clock, J, not-K, set, reset, outputs.
// - Async set low, reset high: true output high, complement low.
// - Async reset low, set high: true output low, complement high.
// - Both async inputs low: both outputs high, not persisting afterwards.
// - Update only on rising channel clock; J and not-K high sets, both low resets.
// - Between rising edges outputs hold; J and not-K changes do nothing.
// - Rising edge with J high, not-K low toggles the output.
`timescale 1ns/1ps
`default_nettype none
module dual_jk_flip_flop
(
    input  wire logic                                  clock,
    input  wire logic                                  rst_n,
    input  wire logic                                  clk_en,
    input  wire jk_pkg::chan_in_type [jk_pkg::CHANNELS-1:0]  chan_in,
    output var  jk_pkg::chan_out_type [jk_pkg::CHANNELS-1:0] chan_out
);
    import jk_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; pins come from outside the clock domain
    chan_in_type [CHANNELS-1:0] sync1_r;
    chan_in_type [CHANNELS-1:0] sync2_r;
    logic [CHANNELS-1:0]        clk_prev_r;
    logic [CHANNELS-1:0]        state_r;
    chan_in_type [CHANNELS-1:0] sync1_nxt;
    chan_in_type [CHANNELS-1:0] sync2_nxt;
    logic [CHANNELS-1:0]        clk_prev_nxt;
    logic [CHANNELS-1:0]        state_nxt;
    chan_out_type [CHANNELS-1:0] out_nxt;

    // Next values: each channel computed alone, no cross terms
    always_comb
    begin
        sync1_nxt    = chan_in;
        sync2_nxt    = sync1_r;
        clk_prev_nxt = clk_prev_r;
        state_nxt    = state_r;
        out_nxt      = chan_out;
        for (int i = 0; i < CHANNELS; i++)
        begin
            clk_prev_nxt[i] = sync2_r[i].clk_pin;
            if (!sync2_r[i].async_set_n && !sync2_r[i].async_reset_n)
            begin
                // Unstable both-low case; state left as it was
                out_nxt[i].q   = 1'b1;
                out_nxt[i].q_n = 1'b1;
            end
            else
            begin
                if (!sync2_r[i].async_set_n)
                    state_nxt[i] = 1'b1;
                else if (!sync2_r[i].async_reset_n)
                    state_nxt[i] = 1'b0;
                else if (sync2_r[i].clk_pin && !clk_prev_r[i])
                begin
                    // Rising edge only; otherwise hold
                    case ({sync2_r[i].j, sync2_r[i].k_n})
                        2'b11:   state_nxt[i] = 1'b1;
                        2'b00:   state_nxt[i] = 1'b0;
                        2'b10:   state_nxt[i] = ~state_r[i];
                        2'b01:   state_nxt[i] = state_r[i];
                        default: state_nxt[i] = state_r[i];
                    endcase
                end
                // Outputs always complementary here
                out_nxt[i].q   = state_nxt[i];
                out_nxt[i].q_n = ~state_nxt[i];
            end
        end
    end

    // Registers; clk_en freezes everything, reset is synchronous
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            sync1_r    <= '0;
            sync2_r    <= '0;
            clk_prev_r <= '0;
            state_r    <= {CHANNELS{STATE_RESET}};
            for (int i = 0; i < CHANNELS; i++)
            begin
                chan_out[i].q   <= STATE_RESET;
                chan_out[i].q_n <= ~STATE_RESET;
            end
        end
        else if (clk_en)
        begin
            sync1_r    <= sync1_nxt;
            sync2_r    <= sync2_nxt;
            clk_prev_r <= clk_prev_nxt;
            state_r    <= state_nxt;
            chan_out   <= out_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions on channel 0 behaviour, plus channel 1 edge independence, as seen through the synchroniser
    sequence rise0_s;
        sync2_r[0].clk_pin && !clk_prev_r[0] && sync2_r[0].async_set_n && sync2_r[0].async_reset_n;
    endsequence

    set_force_a: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && !sync2_r[0].async_set_n && sync2_r[0].async_reset_n |=> chan_out[0].q && !chan_out[0].q_n)
        else $error("async set did not force output high");
    reset_force_a: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && sync2_r[0].async_set_n && !sync2_r[0].async_reset_n |=> !chan_out[0].q && chan_out[0].q_n)
        else $error("async reset did not force output low");
    both_low_a: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && !sync2_r[0].async_set_n && !sync2_r[0].async_reset_n |=> chan_out[0].q && chan_out[0].q_n)
        else $error("both async low did not drive both outputs high");
    set_edge_a: assert property (@(posedge clock) disable iff (!rst_n)
        rise0_s and (clk_en && sync2_r[0].j && sync2_r[0].k_n) |=> chan_out[0].q)
        else $error("set edge did not set output");
    toggle_edge_a: assert property (@(posedge clock) disable iff (!rst_n)
        rise0_s and (clk_en && sync2_r[0].j && !sync2_r[0].k_n) |=> state_r[0] != $past(state_r[0]))
        else $error("toggle edge did not invert state");
    hold_edge_a: assert property (@(posedge clock) disable iff (!rst_n)
        rise0_s and (clk_en && !sync2_r[0].j && sync2_r[0].k_n) |=> $stable(state_r[0]))
        else $error("hold edge changed state");
    no_edge_a: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && sync2_r[0].async_set_n && sync2_r[0].async_reset_n
        && !(sync2_r[0].clk_pin && !clk_prev_r[0]) |=> $stable(state_r[0]))
        else $error("state changed without rising edge");
    complement_a: assert property (@(posedge clock) disable iff (!rst_n)
        !(chan_out[0].q && chan_out[0].q_n) |-> chan_out[0].q_n == !chan_out[0].q)
        else $error("complement output not inverse");
    chan_indep_a: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && sync2_r[1].async_set_n && sync2_r[1].async_reset_n
        && !(sync2_r[1].clk_pin && !clk_prev_r[1]) |=> $stable(state_r[1]))
        else $error("channel 1 changed without its own edge");

    ////////////////////////////////////////////////////////////////////////
    // Clearing code, output tracking and both-low hold on channel 0; clock enable, synchroniser and edge history on both channels

    // Both low clears on an edge; twin of the set check
    clear_edge_a: assert property (@(posedge clock) disable iff (!rst_n)
        rise0_s and (clk_en && !sync2_r[0].j && !sync2_r[0].k_n) |=> !chan_out[0].q && chan_out[0].q_n)
        else $error("clear edge did not clear output");

    // Enable low must freeze the synchroniser too, or a pin edge would leak past
    freeze_a: assert property (@(posedge clock) disable iff (!rst_n)
        !clk_en |=> $stable(state_r) && $stable(chan_out) && $stable(sync2_r) && $stable(clk_prev_r))
        else $error("state moved while clock enable low");

    // Two-flop path moves one stage per enabled clock
    sync_age_a: assert property (@(posedge clock) disable iff (!rst_n) // Synchroniser
        clk_en |=> sync2_r == $past(sync1_r))
        else $error("synchroniser skipped a stage");

    // Edge detector holds the last synchronised channel clock levels
    clk_prev_a: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en |=> clk_prev_r == $past({sync2_r[1].clk_pin, sync2_r[0].clk_pin}))
        else $error("edge detector history wrong");

    // Outside both-low the true output mirrors the held state
    track0_a: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && (sync2_r[0].async_set_n || sync2_r[0].async_reset_n) |=> chan_out[0].q == state_r[0])
        else $error("channel 0 output does not follow its state");

    // Both-low keeps the state, so releasing both restores the old level
    both_keep0_a: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && !sync2_r[0].async_set_n && !sync2_r[0].async_reset_n |=> $stable(state_r[0]))
        else $error("channel 0 state moved while both async low");

    ////////////////////////////////////////////////////////////////////////
    // Channel 1 checked on its own, so a crossed index shows up

    // Channel 1 rising edge with both async inputs inactive
    sequence rise1_s;
        sync2_r[1].clk_pin && !clk_prev_r[1] && sync2_r[1].async_set_n && sync2_r[1].async_reset_n;
    endsequence

    // Async set alone forces channel 1 high
    set_force1_a: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && !sync2_r[1].async_set_n && sync2_r[1].async_reset_n |=> chan_out[1].q && !chan_out[1].q_n)
        else $error("channel 1 async set did not force output high");

    // Async reset alone forces channel 1 low
    reset_force1_a: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && sync2_r[1].async_set_n && !sync2_r[1].async_reset_n |=> !chan_out[1].q && chan_out[1].q_n)
        else $error("channel 1 async reset did not force output low");

    // Both async low drives both channel 1 outputs high
    both_low1_a: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && !sync2_r[1].async_set_n && !sync2_r[1].async_reset_n |=> chan_out[1].q && chan_out[1].q_n)
        else $error("channel 1 both async low did not drive both high");

    // Both-low leaves channel 1 state untouched
    both_keep1_a: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && !sync2_r[1].async_set_n && !sync2_r[1].async_reset_n |=> $stable(state_r[1]))
        else $error("channel 1 state moved while both async low");

    // Set code on a channel 1 edge
    set_edge1_a: assert property (@(posedge clock) disable iff (!rst_n)
        rise1_s and (clk_en && sync2_r[1].j && sync2_r[1].k_n) |=> chan_out[1].q)
        else $error("channel 1 set edge did not set output");

    // Clear code on a channel 1 edge
    clear_edge1_a: assert property (@(posedge clock) disable iff (!rst_n)
        rise1_s and (clk_en && !sync2_r[1].j && !sync2_r[1].k_n) |=> !chan_out[1].q)
        else $error("channel 1 clear edge did not clear output");

    // Toggle code on a channel 1 edge
    toggle_edge1_a: assert property (@(posedge clock) disable iff (!rst_n)
        rise1_s and (clk_en && sync2_r[1].j && !sync2_r[1].k_n) |=> state_r[1] != $past(state_r[1]))
        else $error("channel 1 toggle edge did not invert state");

    // Hold code on a channel 1 edge
    hold_edge1_a: assert property (@(posedge clock) disable iff (!rst_n)
        rise1_s and (clk_en && !sync2_r[1].j && sync2_r[1].k_n) |=> $stable(state_r[1]))
        else $error("channel 1 hold edge changed state");

    // Channel 1 outputs complementary unless both are high
    complement1_a: assert property (@(posedge clock) disable iff (!rst_n)
        !(chan_out[1].q && chan_out[1].q_n) |-> chan_out[1].q_n == !chan_out[1].q)
        else $error("channel 1 complement output not inverse");

    // Channel 1 true output mirrors its held state outside both-low
    track1_a: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && (sync2_r[1].async_set_n || sync2_r[1].async_reset_n) |=> chan_out[1].q == state_r[1])
        else $error("channel 1 output does not follow its state");
endmodule
`default_nettype wire

// ===== testbench/pin_driver.sv
// Board-side model driving both channels' pins
`timescale 1ns/1ps
`default_nettype none
module pin_driver
(
    input  wire logic                                       clock,
    output var  jk_pkg::chan_in_type [jk_pkg::CHANNELS-1:0] pins
);
    import jk_pkg::*;
    // Idle: channel clock low, hold code, both async inputs inactive
    initial pins = {CHANNELS{5'h07}};
    // Levels move 1 ns after an edge and stand 3 clocks, past the two-flop sync
    task automatic put(input int ch, input logic [4:0] v);
        @(posedge clock) #1 pins[ch] = v;
        repeat (3) @(posedge clock);
    endtask
    // Channel clock high then low 3 clocks each; J and not-K held meanwhile
    task automatic tick(input int ch);
        put(ch, {1'b1, pins[ch][3:0]});
        put(ch, {1'b0, pins[ch][3:0]});
    endtask
endmodule
`default_nettype wire

// ===== testbench/tb_dual_jk_flip_flop.sv
// Self-checking bench for the dual J/not-K flip-flop block
`timescale 1ns/1ps
`default_nettype none
module tb_dual_jk_flip_flop;
    import jk_pkg::*;
    logic                        clock;
    logic                        rst_n;
    logic                        clk_en;
    chan_in_type  [CHANNELS-1:0] pins;
    chan_out_type [CHANNELS-1:0] outs;
    int                          error_cnt;
    int                          num_checks;
    dual_jk_flip_flop u_dut (.clock(clock), .rst_n(rst_n), .clk_en(clk_en), .chan_in(pins), .chan_out(outs));
    pin_driver u_pins (.clock(clock), .pins(pins));
    // 25 MHz system clock
    initial
    begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    // Compare one channel's {q,q_n} once the edge's updates have landed
    task automatic chk(input int ch, input logic [1:0] exp);
        @(posedge clock) #2;
        num_checks++;
        if (outs[ch] !== exp)
        begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, outs[ch], exp);
        end
    endtask
    // Drive pins, optionally clock the channel, then compare
    task automatic step(input int ch, input logic [4:0] v, input bit clk, input logic [1:0] exp);
        u_pins.put(ch, v);
        if (clk)
            u_pins.tick(ch);
        chk(ch, exp);
    endtask
    task automatic end_sim();
        $display("checks=%0d errors=%0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Async inputs on channel 0, with clock pulses that must not matter
    task automatic t_async();
        step(0, 5'h0d, 1, 2'h2);
        step(0, 5'h0e, 1, 2'h1);
        step(0, 5'h04, 0, 2'h3);
        step(0, 5'h06, 0, 2'h1);
        chk(1, 2'h1);
    endtask
    // Clocked codes on channel 0, D-type use on channel 1
    task automatic t_sync();
        step(0, 5'h0f, 1, 2'h2);
        step(0, 5'h07, 1, 2'h2);
        step(0, 5'h0b, 1, 2'h1);
        step(0, 5'h0b, 1, 2'h2);
        step(0, 5'h03, 0, 2'h2);
        step(0, 5'h03, 1, 2'h1);
        step(1, 5'h0f, 1, 2'h2);
        chk(0, 2'h1);
    endtask
    // Enable low freezes channel 1 through a clear code and a pulse; D-type low after
    task automatic t_enable();
        @(posedge clock) #1 clk_en = 1'b0;
        step(1, 5'h03, 1, 2'h2);
        @(posedge clock) #1 clk_en = 1'b1;
        step(1, 5'h03, 1, 2'h1);
    endtask
    // Synchronous reset held 20 cycles, then the scenarios
    initial
    begin
        rst_n = 1'b0;
        clk_en = 1'b1;
        error_cnt = 0;
        num_checks = 0;
        repeat (20) @(posedge clock);
        #1 rst_n = 1'b1;
        t_async();
        t_sync();
        t_enable();
        end_sim();
    end
    // Scenarios need about 170 cycles; a hang is cut at 3000
    initial
    begin
        repeat (3000) @(posedge clock);
        error_cnt++;
        end_sim();
    end
endmodule
`default_nettype wire
